// ==== core/srsa_pkg.sv ====
// shared constants and carrier types for the security-register / reset / parameter-table command logic
// assumes a host SPI master on the link and a 200 MHz core clock
package srsa_pkg;
    localparam logic [7:0] OP_SEC_READ  = 8'h48;
    localparam logic [7:0] OP_RST_EN    = 8'h66;
    localparam logic [7:0] OP_RST       = 8'h99;
    localparam logic [7:0] OP_SFDP_READ = 8'h5a;
    // link bit counts: opcode end, address end, end of dummy byte
    localparam logic [5:0] OPC_BITS     = 6'h08;
    localparam logic [5:0] ADDR_END     = 6'h20;
    localparam logic [5:0] HDR_END      = 6'h28;
    localparam int         FIFO_WIDTH   = 8;
    localparam int         FIFO_DEPTH   = 32;
    localparam int         CLK_PERIOD_PS  = 5000;
    localparam int         RST_RECOVER_NS = 30000;
    localparam logic [8:0] SEC_BYTE_LAST = 9'h1ff;
    localparam logic [8:0] SEC_BYTE_FIRST = 9'h000;
    localparam logic [7:0] READ_FILL    = 8'hff;
    localparam logic [4:0] SFDP_LAST    = 5'h17;

    typedef struct packed {
        logic [7:0] statusVolatile;
        logic       write_enable_latch;
        logic       suspend_flag;
        logic [7:0] read_parameter_field;
        logic       deepPowerDown;
        logic [7:0] continuous_read_mode_byte;
        logic [2:0] wrap_setting_field;
    } srsa_vol_t;
    localparam srsa_vol_t VOL_RESET = '0;

    typedef enum logic [2:0] {
        PR_IDLE = 3'b001,
        PR_SEC  = 3'b010,
        PR_SFDP = 3'b100
    } srsa_prod_t;

    // frame-local link state, cleared whenever chip select is high
    typedef struct packed {
        logic [5:0] cnt;
        logic       addrDone;
        logic       req;
        logic       ackMeta;
        logic       ackSync;
        logic [7:0] nextByte;
        logic       nextValid;
        logic [7:0] outByte;
        logic       outValid;
        logic [2:0] bitPos;
    } srsa_lnk_t;

    // frame record that survives chip select release, read by the core after the frame
    typedef struct packed {
        logic       seq;
        logic [5:0] bits;
        logic [7:0] opcode;
        logic [23:0] addr;
    } srsa_rec_t;

    typedef struct packed {
        logic       csMeta;
        logic       csSync;
        logic       csPrev;
        logic       doneMeta;
        logic       doneSync;
        logic       donePrev;
        logic       reqMeta;
        logic       reqSync;
        logic       seqSeen;
        logic       armed;
        logic       swReset;
        logic [15:0] busyCnt;
        srsa_prod_t state;
        logic [23:0] fetch;
        logic       ack;
        logic [7:0] holdData;
        srsa_vol_t  vol;
    } srsa_core_t;
endpackage

// ==== core/srsa_fifo.sv ====
// synchronous fifo with valid/ready on both sides and a flush
// assumes one clock; flush wins over push and pop
`timescale 1ns/100ps
`default_nettype none
module srsa_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,      // core clock
    input  wire logic             reset,    // async, active high
    input  wire logic             flush,    // drop all entries
    input  wire logic             inValid,  // producer has a word
    output logic                  inReady,  // space available
    input  wire logic [WIDTH-1:0] inData,   // word in
    output logic                  outValid, // word available
    input  wire logic             outReady, // consumer takes the word
    output logic      [WIDTH-1:0] outData   // word out
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = DEPTH[AW:0];

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } srsa_fifo_st_t;

    srsa_fifo_st_t st_r, st_nxt;
    logic          doPush;
    logic          doPop;

    assign inReady  = st_r.cnt != FULL;
    assign outValid = st_r.cnt != '0;
    assign outData  = st_r.mem[st_r.rp];
    assign doPush   = inValid & inReady;
    assign doPop    = outValid & outReady;

    always_comb begin
        st_nxt = st_r;
        if (flush) begin
            st_nxt.wp  = '0;
            st_nxt.rp  = '0;
            st_nxt.cnt = '0;
        end else begin
            if (doPush) begin
                st_nxt.mem[st_r.wp] = inData;
                st_nxt.wp = st_r.wp + 1'b1;
            end
            if (doPop) begin
                st_nxt.rp = st_r.rp + 1'b1;
            end
            st_nxt.cnt = st_r.cnt + {{AW{1'b0}}, doPush} - {{AW{1'b0}}, doPop};
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule // srsa_fifo
`default_nettype wire

// ==== core/srsa_top.sv ====
// security-register read, two-frame software reset and parameter-table read for a serial flash
// assumes sclk runs only inside frames; ref_clk free running at 200 MHz
`timescale 1ns/100ps
`default_nettype none
module srsa_top #(
    parameter int         RST_RECOVER_CYC = (srsa_pkg::RST_RECOVER_NS * 1000 + srsa_pkg::CLK_PERIOD_PS - 1)
                                            / srsa_pkg::CLK_PERIOD_PS,
    parameter logic [7:0] MAKER_CODE      = 8'h5e  // arbitrary value
) (
    input  wire logic                ref_clk,      // core clock
    input  wire logic                reset,        // async, active high
    input  wire logic                csN,          // chip select pin, active low
    input  wire logic                sclk,         // serial clock from host
    input  wire logic                mosi,         // serial data in
    output logic                     miso,         // serial data out
    output logic                     misoOe,       // serial out driven
    output logic [10:0]              secRdAddr,    // security array index {reg-1..3, byte}
    input  wire logic [7:0]          secRdData,    // security array byte, same cycle
    input  wire logic                volLoad,      // load volatile settings
    input  wire srsa_pkg::srsa_vol_t volIn,        // volatile settings to load
    output srsa_pkg::srsa_vol_t      volState,     // current volatile settings
    output logic                     swResetPulse, // reset accepted, abort ongoing work
    output logic                     recoveryBusy  // reset recovery in progress
);
    localparam logic [15:0] RST_CYC = RST_RECOVER_CYC[15:0];

    srsa_pkg::srsa_lnk_t  lnk_r, lnk_nxt;
    srsa_pkg::srsa_rec_t  rec_r, rec_nxt;
    srsa_pkg::srsa_core_t core_r, core_nxt;
    logic                 linkRst;
    logic                 take;
    logic                 load;
    logic                 isRead;
    logic                 misoBit_r;
    logic                 misoOe_r;
    logic                 frameEnd;
    logic                 newFrame;
    logic                 push;
    logic                 pop;
    logic                 prodValid;
    logic                 fifoInReady;
    logic                 fifoOutValid;
    logic [7:0]           fifoOutData;
    logic [7:0]           pushData;
    logic                 secSelOk;

    function automatic logic [7:0] sfdpByte(input logic [23:0] a);
        sfdpByte = srsa_pkg::READ_FILL;
        if (a[23:5] == '0) begin
            case (a[4:0])
                5'h00: sfdpByte = 8'h53;
                5'h01: sfdpByte = 8'h46;
                5'h02: sfdpByte = 8'h44;
                5'h03: sfdpByte = 8'h50;
                5'h05, 5'h06, 5'h0a, 5'h12: sfdpByte = 8'h01;
                5'h04, 5'h08, 5'h09, 5'h0d, 5'h0e, 5'h11, 5'h15, 5'h16: sfdpByte = 8'h00;
                5'h0b: sfdpByte = 8'h09;
                5'h0c: sfdpByte = 8'h30;
                5'h10: sfdpByte = MAKER_CODE;
                5'h13: sfdpByte = 8'h03;
                5'h14: sfdpByte = 8'h60;
                default: sfdpByte = srsa_pkg::READ_FILL;
            endcase
        end
    endfunction

    // ---------------- link domain ----------------
    assign linkRst = reset | csN;
    assign take    = lnk_r.req & lnk_r.ackSync;
    assign load    = (lnk_r.cnt == srsa_pkg::HDR_END - 6'h01) |
                     ((lnk_r.cnt == srsa_pkg::HDR_END) & (lnk_r.bitPos == 3'h7));
    assign isRead  = (rec_r.opcode == srsa_pkg::OP_SEC_READ) | (rec_r.opcode == srsa_pkg::OP_SFDP_READ);

    always_comb begin
        lnk_nxt = lnk_r;
        rec_nxt = rec_r;
        lnk_nxt.ackMeta = core_r.ack;
        lnk_nxt.ackSync = lnk_r.ackMeta;
        if (lnk_r.cnt == 6'h00) begin
            rec_nxt.seq = ~rec_r.seq;
        end
        if (lnk_r.cnt != srsa_pkg::HDR_END) begin
            lnk_nxt.cnt  = lnk_r.cnt + 6'h01;
            rec_nxt.bits = lnk_r.cnt + 6'h01;
        end
        if (lnk_r.cnt < srsa_pkg::OPC_BITS) begin
            rec_nxt.opcode = {rec_r.opcode[6:0], mosi};
        end else if (lnk_r.cnt < srsa_pkg::ADDR_END) begin
            rec_nxt.addr = {rec_r.addr[22:0], mosi};
        end
        if (lnk_r.cnt == srsa_pkg::ADDR_END - 6'h01) begin
            lnk_nxt.addrDone = 1'b1;
        end
        if (load) begin
            lnk_nxt.outByte   = lnk_r.nextValid ? lnk_r.nextByte : core_r.holdData;
            lnk_nxt.outValid  = lnk_r.nextValid | take;
            lnk_nxt.nextValid = 1'b0;
            lnk_nxt.bitPos    = 3'h0;
        end else begin
            if (lnk_r.cnt == srsa_pkg::HDR_END) begin
                lnk_nxt.bitPos = lnk_r.bitPos + 3'h1;
            end
            if (take) begin
                lnk_nxt.nextByte  = core_r.holdData;
                lnk_nxt.nextValid = 1'b1;
            end
        end
        // four-phase byte fetch from the core, one byte ahead of the shifter
        if (take) begin
            lnk_nxt.req = 1'b0;
        end else if (!lnk_r.req && !lnk_r.ackSync && !lnk_r.nextValid && lnk_r.addrDone && isRead) begin
            lnk_nxt.req = 1'b1;
        end
    end

    always_ff @(posedge sclk or posedge linkRst) begin
        if (linkRst) begin
            lnk_r <= '0;
        end else begin
            lnk_r <= lnk_nxt;
        end
    end

    always_ff @(posedge sclk or posedge reset) begin
        if (reset) begin
            rec_r <= '0;
        end else begin
            rec_r <= rec_nxt;
        end
    end

    // output bit changes on the falling edge
    always_ff @(negedge sclk or posedge linkRst) begin
        if (linkRst) begin
            misoBit_r <= 1'b0;
            misoOe_r  <= 1'b0;
        end else begin
            misoBit_r <= lnk_r.outByte[~lnk_r.bitPos];
            misoOe_r  <= lnk_r.outValid & (lnk_r.cnt == srsa_pkg::HDR_END);
        end
    end

    assign miso   = misoBit_r;
    assign misoOe = misoOe_r;

    // ---------------- core domain ----------------
    assign frameEnd  = core_r.csSync & ~core_r.csPrev;
    assign newFrame  = rec_r.seq != core_r.seqSeen;
    assign prodValid = core_r.state != srsa_pkg::PR_IDLE;
    assign push      = prodValid & fifoInReady;
    assign pop       = core_r.reqSync & ~core_r.ack & fifoOutValid;
    assign secSelOk  = (core_r.fetch[23:16] == 8'h00) & (core_r.fetch[15:14] == 2'h0) &
                       (core_r.fetch[13:12] != 2'h0) & (core_r.fetch[11:9] == 3'h0);
    assign secRdAddr = {core_r.fetch[13:12], core_r.fetch[8:0]};
    assign pushData  = (core_r.state == srsa_pkg::PR_SFDP) ? sfdpByte(core_r.fetch) :
                       (secSelOk ? secRdData : srsa_pkg::READ_FILL);

    always_comb begin
        core_nxt = core_r;
        core_nxt.csMeta   = csN;
        core_nxt.csSync   = core_r.csMeta;
        core_nxt.csPrev   = core_r.csSync;
        core_nxt.doneMeta = lnk_r.addrDone;
        core_nxt.doneSync = core_r.doneMeta;
        core_nxt.donePrev = core_r.doneSync;
        core_nxt.reqMeta  = lnk_r.req;
        core_nxt.reqSync  = core_r.reqMeta;
        core_nxt.swReset  = 1'b0;
        if (recoveryBusy) begin
            core_nxt.busyCnt = core_r.busyCnt - 16'h0001;
        end
        if (volLoad && !recoveryBusy) begin
            core_nxt.vol = volIn;
        end
        case (core_r.state)
            srsa_pkg::PR_IDLE: begin
                if (core_r.doneSync && !core_r.donePrev && !core_r.csSync && !recoveryBusy) begin
                    core_nxt.fetch = rec_r.addr;
                    if (rec_r.opcode == srsa_pkg::OP_SEC_READ) begin
                        core_nxt.state = srsa_pkg::PR_SEC;
                    end else if (rec_r.opcode == srsa_pkg::OP_SFDP_READ) begin
                        core_nxt.state = srsa_pkg::PR_SFDP;
                    end
                end
            end
            srsa_pkg::PR_SEC: begin
                if (push) begin
                    core_nxt.fetch[8:0] = (core_r.fetch[8:0] == srsa_pkg::SEC_BYTE_LAST) ?
                                          srsa_pkg::SEC_BYTE_FIRST : core_r.fetch[8:0] + 9'h001;
                end
            end
            srsa_pkg::PR_SFDP: begin
                if (push) begin
                    core_nxt.fetch = core_r.fetch + 24'h000001;
                end
            end
            default: begin
                core_nxt.state = srsa_pkg::PR_IDLE;
            end
        endcase
        if (!core_r.reqSync) begin
            core_nxt.ack = 1'b0;
        end else if (pop) begin
            core_nxt.ack      = 1'b1;
            core_nxt.holdData = fifoOutData;
        end
        // the read ends only with chip select; command frames are judged here
        if (frameEnd) begin
            core_nxt.seqSeen = rec_r.seq;
            core_nxt.state   = srsa_pkg::PR_IDLE;
            if (recoveryBusy || !newFrame) begin
                core_nxt.armed = 1'b0;
            end else if (rec_r.bits == srsa_pkg::OPC_BITS && rec_r.opcode == srsa_pkg::OP_RST && core_r.armed) begin
                core_nxt.armed   = 1'b0;
                core_nxt.swReset = 1'b1;
                core_nxt.vol     = srsa_pkg::VOL_RESET;
                core_nxt.busyCnt = RST_CYC;
            end else begin
                core_nxt.armed = (rec_r.bits == srsa_pkg::OPC_BITS) && (rec_r.opcode == srsa_pkg::OP_RST_EN);
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            core_r <= '{csMeta: 1'b1, csSync: 1'b1, csPrev: 1'b1, state: srsa_pkg::PR_IDLE,
                        vol: srsa_pkg::VOL_RESET, default: '0};
        end else begin
            core_r <= core_nxt;
        end
    end

    srsa_fifo #(
        .WIDTH (srsa_pkg::FIFO_WIDTH),
        .DEPTH (srsa_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk      (ref_clk),
        .reset    (reset),
        .flush    (frameEnd),
        .inValid  (prodValid),
        .inReady  (fifoInReady),
        .inData   (pushData),
        .outValid (fifoOutValid),
        .outReady (pop),
        .outData  (fifoOutData)
    );

    assign volState     = core_r.vol;
    assign swResetPulse = core_r.swReset;
    assign recoveryBusy = core_r.busyCnt != 16'h0000;

    // ---------------- checks ----------------
    a_req_after_addr: assert property (@(posedge sclk) disable iff (linkRst)
        lnk_r.req |-> lnk_r.addrDone && lnk_r.cnt >= srsa_pkg::ADDR_END)
        else $error("byte fetch before address complete");
    a_reset_accept: assert property (@(posedge ref_clk) disable iff (reset)
        frameEnd && !recoveryBusy && newFrame && core_r.armed && rec_r.bits == srsa_pkg::OPC_BITS &&
        rec_r.opcode == srsa_pkg::OP_RST
        |=> core_r.swReset)
        else $error("reset pair not accepted");
    a_reset_abort: assert property (@(posedge ref_clk) disable iff (reset)
        core_r.swReset |-> core_r.state == srsa_pkg::PR_IDLE && !core_r.armed)
        else $error("reset left work running");
    a_vol_cleared: assert property (@(posedge ref_clk) disable iff (reset)
        core_r.swReset |-> core_r.vol == '0 ##1 (core_r.vol == '0 || $past(volLoad)))
        else $error("volatile state not cleared");
    a_recover_hold: assert property (@(posedge ref_clk) disable iff (reset)
        core_r.swReset |-> recoveryBusy [*8])
        else $error("recovery window too short");
    a_busy_ignore: assert property (@(posedge ref_clk) disable iff (reset)
        recoveryBusy && frameEnd |=> !core_r.swReset && !core_r.armed)
        else $error("command taken during recovery");
    a_sec_incr: assert property (@(posedge ref_clk) disable iff (reset)
        push && core_r.state == srsa_pkg::PR_SEC && core_r.fetch[8:0] != 9'h1ff && !frameEnd
        |=> core_r.fetch[8:0] == $past(core_r.fetch[8:0]) + 9'h001)
        else $error("byte address did not advance");
    a_sec_wrap: assert property (@(posedge ref_clk) disable iff (reset)
        push && core_r.state == srsa_pkg::PR_SEC && core_r.fetch[8:0] == 9'h1ff && !frameEnd
        |=> core_r.fetch[8:0] == 9'h000 && core_r.fetch[23:9] == $past(core_r.fetch[23:9]))
        else $error("byte address did not wrap");
    a_sfdp_unused: assert property (@(posedge ref_clk) disable iff (reset)
        core_r.state == srsa_pkg::PR_SFDP && core_r.fetch inside {24'h07, 24'h0f, 24'h17} |-> pushData == 8'hff)
        else $error("unused table byte not all ones");
    a_sfdp_sig: assert property (@(posedge ref_clk) disable iff (reset)
        push && core_r.state == srsa_pkg::PR_SFDP && core_r.fetch == 24'h0
        |-> pushData == 8'h53 ##1 (frameEnd || !push || pushData == 8'h46))
        else $error("signature bytes wrong");
    a_sfdp_ptr: assert property (@(posedge ref_clk) disable iff (reset)
        core_r.state == srsa_pkg::PR_SFDP && core_r.fetch == 24'h0c |-> pushData == 8'h30)
        else $error("first table pointer wrong");

    c_reset_taken: cover property (@(posedge ref_clk) disable iff (reset) core_r.swReset);
    c_sec_wrap: cover property (@(posedge ref_clk) disable iff (reset)
        push && core_r.state == srsa_pkg::PR_SEC && core_r.fetch[8:0] == 9'h1ff);
    c_sfdp_hdr2: cover property (@(posedge ref_clk) disable iff (reset)
        push && core_r.state == srsa_pkg::PR_SFDP && core_r.fetch == 24'h16);
    c_byte_out: cover property (@(posedge sclk) disable iff (linkRst) misoOe_r && load);
endmodule // srsa_top
`default_nettype wire

// ==== verif/srsa_host.sv ====
// host spi master model: mode 0, msb first, sclk of 160 ns only inside frames
// assumes the device samples on rising sclk and shifts out on falling sclk
`timescale 1ns/100ps
`default_nettype none
module srsa_host (
    output logic      csN,    // chip select, active low
    output logic      sclk,   // serial clock, idle low
    output logic      mosi,   // data to device
    input  wire logic miso,   // data from device
    input  wire logic misoOe  // device drives miso
);
    logic [7:0] rxByte;
    int         oeBits;
    event       got;

    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
        oeBits = 0;
    end

    // header bits first, then read slots; a byte is reported if the device drives its last bit
    task automatic frame(input logic [39:0] hdr, input int nBits, input int nBytes);
        csN = 1'b0;
        for (int i = 0; i < nBits + 8 * nBytes; i++) begin
            mosi = (i < nBits) ? hdr[39 - i] : ~mosi;
            #80 sclk = 1'b1;
            if (i >= nBits) begin
                rxByte = {rxByte[6:0], miso};
                oeBits += int'(misoOe);
                if (misoOe && (i - nBits) % 8 == 7)
                    ->got;
            end
            #80 sclk = 1'b0;
        end
        #80 csN = 1'b1;
        mosi = ~mosi;
        #400;
    endtask
endmodule // srsa_host
`default_nettype wire

// ==== verif/srsa_top_bench.sv ====
// self-checking bench for the security read, reset pair and parameter table
// assumes the host model in srsa_host.sv and a combinational security array
`timescale 1ns/100ps
`default_nettype none
module srsa_top_bench;
    localparam int         RCYC  = 4000;
    localparam logic [7:0] MAKER = 8'h3c; // arbitrary value
    localparam logic [7:0] TBL [25] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hff,
        8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff, MAKER, 8'h00, 8'h01, 8'h03,
        8'h60, 8'h00, 8'h00, 8'hff, 8'hff};
    logic                refClk, reset, csN, sclk, mosi, miso, misoOe, volLoad, swResetPulse, recoveryBusy;
    logic [10:0]         secRdAddr;
    logic [7:0]          secMem [2048];
    srsa_pkg::srsa_vol_t volIn, volState;
    logic [7:0]          expQ [$];
    logic [31:0]         seed, pulses, busyCnt;
    int                  numErrors, cmpCount, n;

    wire logic [7:0]     secRdData;
    assign secRdData = secMem[secRdAddr];

    srsa_top #(.RST_RECOVER_CYC(RCYC), .MAKER_CODE(MAKER)) uut (.ref_clk(refClk), .reset(reset), .csN(csN),
        .sclk(sclk), .mosi(mosi), .miso(miso), .misoOe(misoOe), .secRdAddr(secRdAddr), .secRdData(secRdData),
        .volLoad(volLoad), .volIn(volIn), .volState(volState), .swResetPulse(swResetPulse),
        .recoveryBusy(recoveryBusy));
    srsa_host host (.csN(csN), .sclk(sclk), .mosi(mosi), .miso(miso), .misoOe(misoOe));

    initial refClk = 1'b0;
    always #2.5 refClk = ~refClk;
    always @(posedge refClk) begin
        pulses <= reset ? 32'h0 : pulses + 32'(swResetPulse);
        busyCnt <= reset ? 32'h0 : busyCnt + 32'(recoveryBusy);
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmpCount++;
        if (g !== e) begin
            numErrors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmpCount, numErrors);
        if (numErrors == 0 && cmpCount > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // oldest note is compared against each byte the host receives
    always @(host.got) begin
        chk({24'h0, host.rxByte}, expQ.size() > 0 ? {24'h0, expQ.pop_front()} : 32'h100);
    end

    task automatic loadVol;
        @(posedge refClk);
        volIn <= srsa_pkg::srsa_vol_t'($random(seed));
        volLoad <= 1'b1;
        @(posedge refClk);
        volLoad <= 1'b0;
        repeat (2) @(posedge refClk);
    endtask

    initial begin
        seed = 32'h00c7;
        reset = 1'b1;
        volLoad = 1'b0;
        volIn = '0;
        numErrors = 0;
        cmpCount = 0;
        for (int i = 0; i < 2048; i++)
            secMem[i] = 8'($random(seed));
        repeat (4) @(posedge refClk);
        reset <= 1'b0;
        repeat (3) @(posedge refClk);
        #1.3;
        for (int r = 1; r <= 3; r++) begin
            for (int k = 0; k < 3; k++)
                expQ.push_back(secMem[{r[1:0], 9'h1fe + 9'(k)}]);
            host.frame({8'h48, 8'h00, r[3:0], 12'h1fe, 8'h00}, 40, 3);
        end
        expQ.push_back(8'hff);
        host.frame({8'h48, 24'h004000, 8'h00}, 40, 1);
        $display("security reads done");
        for (int k = 0; k < 25; k++)
            expQ.push_back(TBL[k]);
        host.frame({8'h5a, 24'h0, 8'h00}, 40, 25);
        n = host.oeBits;
        host.frame({8'h0b, 32'h0}, 40, 1);
        chk(32'(host.oeBits - n), 32'h0);
        chk(32'(expQ.size()), 32'h0);
        $display("parameter table done");
        loadVol();
        chk(32'(volState), 32'(volIn));
        chk(32'(recoveryBusy), 32'h0);
        host.frame({8'h66, 32'h0}, 8, 0);
        host.frame(40'h0, 0, 0);
        host.frame({8'h99, 32'h0}, 8, 0);
        chk(pulses, 32'h0);
        host.frame({8'h66, 32'h0}, 8, 0);
        host.frame({8'h99, 32'h0}, 8, 0);
        chk(pulses, 32'h1);
        chk(32'(volState), 32'(srsa_pkg::VOL_RESET));
        chk(32'(recoveryBusy), 32'h1);
        n = host.oeBits;
        host.frame({8'h66, 32'h0}, 8, 0);
        host.frame({8'h99, 32'h0}, 8, 0);
        host.frame({8'h48, 24'h001000, 8'h00}, 40, 1);
        loadVol();
        chk(32'(host.oeBits - n), 32'h0);
        chk(pulses, 32'h1);
        chk(32'(volState), 32'h0);
        for (int i = 0; i < 20000 && recoveryBusy !== 1'b0; i++)
            @(posedge refClk);
        chk(32'(recoveryBusy), 32'h0);
        if (recoveryBusy === 1'b0) begin
            chk(busyCnt, 32'(RCYC));
            expQ.push_back(secMem[11'h405]);
            host.frame({8'h48, 24'h002005, 8'h00}, 40, 1);
            chk(32'(expQ.size()), 32'h0);
        end
        $display("reset sequence done");
        results();
    end
endmodule // srsa_top_bench
`default_nettype wire
